// [hdl/ddc_checker.sv]
// dual channel diversity checker: merges a/c and inverted b/d ask bits
// assumes channel decoders deliver one record per ask bit each
// Contract
// - balise detect and foreign flags merged by AND
// - unavailable, link test, antenna id compared
// - telegram detect not cross compared
// - any all zero strength forces zero
// - link id checked per channel
// - counter up on a/c, down on b/d
// - opening and closing bits not compared
// - checksum checked per channel only
// - checksum failure skips diversity checks
// - b/d flags and antenna id re-inverted
// - identities supervised only with good checksum
// - strength available only when nonzero
`timescale 1ns/10ps
module ddc_checker
  import ddc_pkg::*;
#(
  parameter logic [LNK_W-1:0] LINK_ID_AC = LNK_ID_AC,
  parameter logic [LNK_W-1:0] LINK_ID_BD = LNK_ID_BD
)
(
  // clock, reset, enable
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  // a/c channel
  input  wire logic        ac_valid,
  input  wire ddc_bit_type ac_bit,
  // b/d channel, inverted fields as sent
  input  wire logic        bd_valid,
  input  wire ddc_bit_type bd_bit,
  // merged result
  output logic             out_valid,
  output ddc_merged_type   out_data,
  output logic             out_div_err,
  // sticky status and acknowledge
  input  wire ddc_err_type err_ack,
  output ddc_err_type      err_sticky
);

  // reset release through two flip-flops
  logic rst_s1_r;
  logic rst_s2_r;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  wire rst_n = rst_s2_r;

  // channel alignment
  logic        ac_held_v;
  logic        bd_held_v;
  ddc_bit_type ac_h;
  ddc_bit_type bd_h;
  wire         pair = ac_held_v & bd_held_v;

  ddc_chan_align u_ac
  (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .in_valid   (ac_valid),
    .in_bit     (ac_bit),
    .take       (pair),
    .held_valid (ac_held_v),
    .held_bit   (ac_h)
  );

  ddc_chan_align u_bd
  (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    .in_valid   (bd_valid),
    .in_bit     (bd_bit),
    .take       (pair),
    .held_valid (bd_held_v),
    .held_bit   (bd_h)
  );

  // re-invert b/d fields before any use
  wire             bd_bd  = ~bd_h.balise_detect;
  wire             bd_td  = ~bd_h.telegram_detect;
  wire             bd_eu  = ~bd_h.unavailable_flag;
  wire             bd_eb  = ~bd_h.foreign_telegram_flag;
  wire             bd_lt  = ~bd_h.link_test_flag;
  wire [ANT_W-1:0] bd_ant = ~bd_h.antenna_id;

  // checksum verdicts per channel, never compared across
  wire crc_both = ac_h.checksum_ok & bd_h.checksum_ok;

  // true compares, gated by good checksums
  wire mismatch = (ac_h.unavailable_flag != bd_eu)
                | (ac_h.link_test_flag != bd_lt)
                | (ac_h.antenna_id != bd_ant);
  // telegram detect, opening/closing bits and checksum are left out
  wire div_err  = pair & crc_both & mismatch;

  // link identity per channel
  wire id_err = pair & crc_both
              & ((ac_h.link_id != LINK_ID_AC)
               | (bd_h.link_id != LINK_ID_BD));

  // bit counter sequences
  logic             cnt_seen_r;
  logic [CNT_W-1:0] ac_cnt_r;
  logic [CNT_W-1:0] bd_cnt_r;
  wire [CNT_W-1:0]  ac_exp = CNT_W'(ac_cnt_r + CNT_STEP);
  wire [CNT_W-1:0]  bd_exp = CNT_W'(bd_cnt_r - CNT_STEP);
  wire              cnt_err = pair & cnt_seen_r
                            & ((ac_h.bit_count != ac_exp)
                             | (bd_h.bit_count != bd_exp));

  // merge: AND for zero-precedence flags, strength zero wins
  wire ss_zero = (ac_h.strength == SS_NONE)
               | (bd_h.strength == SS_NONE);
  ddc_merged_type merged;
  assign merged.balise_detect         = ac_h.balise_detect & bd_bd;
  assign merged.foreign_telegram_flag = ac_h.foreign_telegram_flag
                                      & bd_eb;
  assign merged.telegram_detect       = ac_h.telegram_detect | bd_td;
  assign merged.unavailable_flag      = ac_h.unavailable_flag | bd_eu;
  assign merged.link_test_flag        = ac_h.link_test_flag | bd_lt;
  assign merged.strength       = ss_zero ? SS_NONE : ac_h.strength;
  assign merged.strength_avail = ~ss_zero;
  assign merged.antenna_id     = ac_h.antenna_id;
  assign merged.checks_done    = crc_both;

  // output registers, one record per paired ask bit
  logic           out_valid_r;
  ddc_merged_type out_data_r;
  logic           out_div_r;
  ddc_err_type    err_r;
  ddc_err_type    err_nxt;

  assign err_nxt.diversity = div_err | (err_r.diversity & ~err_ack.diversity);
  assign err_nxt.identity  = id_err  | (err_r.identity  & ~err_ack.identity);
  assign err_nxt.counter   = cnt_err | (err_r.counter   & ~err_ack.counter);

  // counter history tracks the last paired bit on each channel
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_seen_r <= 1'b0;
      ac_cnt_r   <= '0;
      bd_cnt_r   <= '0;
    end
    else if (ce && pair)
    begin
      cnt_seen_r <= 1'b1;
      ac_cnt_r   <= ac_h.bit_count;
      bd_cnt_r   <= bd_h.bit_count;
    end
  end

  // results and sticky flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
      out_div_r   <= 1'b0;
      err_r       <= '0;
    end
    else if (ce)
    begin
      out_valid_r <= pair;
      out_div_r   <= div_err;
      err_r       <= err_nxt;
      if (pair)
        out_data_r <= merged;
    end
  end

  assign out_valid   = out_valid_r;
  assign out_data    = out_data_r;
  assign out_div_err = out_div_r;
  assign err_sticky  = err_r;

endmodule

// [hdl/ddc_pkg.sv]
// package for the dual channel diversity checker: field layout and constants
// assumes one decoded ask bit record per channel, each with a checksum verdict
package ddc_pkg;

  localparam int SS_W   = 4;   // signal strength width
  localparam int ANT_W  = 4;   // antenna identity width
  localparam int LNK_W  = 2;   // link identity width
  localparam int CNT_W  = 3;   // bit counter width (modulo 8)

  localparam logic [SS_W-1:0]  SS_NONE   = 4'h0;
  localparam logic [CNT_W-1:0] CNT_STEP  = 3'h1;
  localparam logic [LNK_W-1:0] LNK_ID_AC = 2'h1;  // expected on a/c
  localparam logic [LNK_W-1:0] LNK_ID_BD = 2'h2;  // expected on b/d

  // one decoded ask bit as delivered by a channel decoder
  typedef struct packed {
    logic              balise_detect;
    logic              telegram_detect;
    logic              unavailable_flag;
    logic              foreign_telegram_flag;
    logic              link_test_flag;
    logic [SS_W-1:0]   strength;
    logic [ANT_W-1:0]  antenna_id;
    logic [LNK_W-1:0]  link_id;
    logic [CNT_W-1:0]  bit_count;
    logic              checksum_ok;
  } ddc_bit_type;

  // merged result handed to the train receiver module logic
  typedef struct packed {
    logic              balise_detect;
    logic              telegram_detect;
    logic              unavailable_flag;
    logic              foreign_telegram_flag;
    logic              link_test_flag;
    logic [SS_W-1:0]   strength;
    logic              strength_avail;
    logic [ANT_W-1:0]  antenna_id;
    logic              checks_done;
  } ddc_merged_type;

  // sticky error set
  typedef struct packed {
    logic diversity;
    logic identity;
    logic counter;
  } ddc_err_type;

endpackage

// [hdl/ddc_chan_align.sv]
// holds one channel's ask bit until the other channel's arrives
// assumes channels deliver within one ask bit of each other
`timescale 1ns/10ps
module ddc_chan_align
  import ddc_pkg::*;
(
  // clock, reset and enable
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // channel side
  input  wire logic        in_valid,
  input  wire ddc_bit_type in_bit,
  // pairing side
  input  wire logic        take,
  output logic             held_valid,
  output ddc_bit_type      held_bit
);

  logic        held_valid_r;
  ddc_bit_type held_bit_r;

  assign held_valid = held_valid_r;
  assign held_bit   = held_bit_r;

  // load on arrival; a fresh arrival overrides the pair release
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      held_valid_r <= 1'b0;
      held_bit_r   <= '0;
    end
    else if (ce)
    begin
      if (in_valid)
      begin
        held_valid_r <= 1'b1;
        held_bit_r   <= in_bit;
      end
      else if (take)
        held_valid_r <= 1'b0;
    end
  end

endmodule

// [bench/ddc_tx_model.sv]
// far side model: sends one ask bit on both channels at once
// assumes logical records from the bench; b/d flags and antenna id leave inverted
`timescale 1ns/10ps
module ddc_tx_model
  import ddc_pkg::*;
(
  // command
  input  wire logic        clock,
  input  wire logic        send,
  input  wire logic        skip,
  input  wire ddc_bit_type a_in,
  input  wire ddc_bit_type b_in,
  // channels
  output logic             valid,
  output ddc_bit_type      ac_bit,
  output ddc_bit_type      bd_bit
);
  localparam ddc_bit_type INV = 19'h7C3C0;
  logic [CNT_W-1:0] cnt_r = 3'h0;
  wire  [CNT_W-1:0] cnt_nxt = cnt_r + CNT_STEP + {2'h0, skip};
  ddc_bit_type a_rec;
  ddc_bit_type b_rec;
  initial {valid, ac_bit, bd_bit} = '0;
  // full records built first so each output is written once per edge
  always_comb
  begin
    a_rec = a_in;
    a_rec.bit_count = cnt_nxt;
    b_rec = b_in ^ INV;
    b_rec.bit_count = 3'h0 - cnt_nxt;
  end
  // idle records toggle so stale values never look valid
  always @(posedge clock)
  begin
    valid <= send;
    ac_bit <= send ? a_rec : ~ac_bit;
    bd_bit <= send ? b_rec : ~bd_bit;
    if (send)
      cnt_r <= cnt_nxt;
  end
endmodule

// [bench/ddc_checker_props.sv]
// assertions on the diversity checker ports
// assumes both channels of one ask bit arrive together
`timescale 1ns/10ps
module ddc_checker_props
  import ddc_pkg::*;
(
  // clock, reset, enable
  input wire logic           clock,
  input wire logic           rstn,
  input wire logic           ce,
  // channels
  input wire logic           ac_valid,
  input wire ddc_bit_type    ac_bit,
  input wire logic           bd_valid,
  input wire ddc_bit_type    bd_bit,
  // results
  input wire logic           out_valid,
  input wire ddc_merged_type out_data,
  input wire logic           out_div_err,
  input wire ddc_err_type    err_ack,
  input wire ddc_err_type    err_sticky
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // a pair enters, its result leaves two edges later
  sequence pair_in;
    ce && ac_valid && bd_valid;
  endsequence
  sequence pair_out;
    pair_in ##2 out_valid;
  endsequence
  // b/d wire values are inverted, so equal wires mean a mismatch
  wire both_ok = ac_bit.checksum_ok && bd_bit.checksum_ok;
  wire div_bad = both_ok && (ac_bit.antenna_id != ~bd_bit.antenna_id
    || ac_bit.unavailable_flag == bd_bit.unavailable_flag
    || ac_bit.link_test_flag == bd_bit.link_test_flag);
  wire ss_zero = ac_bit.strength == SS_NONE || bd_bit.strength == SS_NONE;
  chk_pair_answer: assert property (pair_in |-> ##2 out_valid)
    else $error("pair gave no result");
  chk_detect_and: assert property (
    pair_out |-> out_data.balise_detect == ($past(ac_bit.balise_detect, 2)
    & ~$past(bd_bit.balise_detect, 2)))
    else $error("detect not anded");
  chk_div_raise: assert property (
    pair_in ##0 div_bad |-> ##2 out_div_err)
    else $error("mismatch not flagged");
  chk_crc_skip: assert property (
    pair_in ##0 !both_ok |-> ##2 !out_div_err)
    else $error("flag despite bad checksum");
  chk_strength_zero: assert property (
    pair_in ##0 ss_zero |-> ##2 out_data.strength == SS_NONE
    && !out_data.strength_avail)
    else $error("zero strength lost");
  chk_link_id: assert property (
    pair_in ##0 (both_ok && ac_bit.link_id != LNK_ID_AC)
    |-> ##2 err_sticky.identity)
    else $error("link id deviation missed");
  chk_sticky_hold: assert property (
    err_sticky.diversity && !err_ack.diversity |=> err_sticky.diversity)
    else $error("sticky error dropped");
  chk_ack_clear: assert property (
    err_ack.counter ##1 !out_valid |-> !err_sticky.counter)
    else $error("ack did not clear");
endmodule
bind ddc_checker ddc_checker_props i_ddc_checker_props (
  .clock(clock), .rstn(rstn), .ce(ce), .ac_valid(ac_valid),
  .ac_bit(ac_bit), .bd_valid(bd_valid), .bd_bit(bd_bit),
  .out_valid(out_valid), .out_data(out_data), .out_div_err(out_div_err),
  .err_ack(err_ack), .err_sticky(err_sticky));

// [bench/ddc_checker_tb_top.sv]
// bench: random ask bit pairs with faults and acks
// assumes ddc_tx_model drives both channels
`timescale 1ns/10ps
module ddc_checker_tb_top
  import ddc_pkg::*;
;
  logic           clock = 1'b0;
  logic           rstn = 1'b0;
  logic           send = 1'b0;
  logic           skip = 1'b0;
  ddc_bit_type    a = '0;
  ddc_bit_type    b = '0;
  ddc_bit_type    m;
  ddc_bit_type    na;
  ddc_bit_type    nb;
  ddc_err_type    err_ack = '0;
  ddc_err_type    exp_s = '0;
  ddc_err_type    e;
  logic           valid, out_valid, out_div_err;
  ddc_bit_type    ac_bit, bd_bit;
  ddc_merged_type out_data;
  ddc_err_type    err_sticky;
  int             mismatches = 0;
  int             checks_done = 0;
  int             cycles = 0;
  // 200 MHz clock
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  ddc_tx_model i_ddc_tx_model (.clock(clock), .send(send), .skip(skip),
    .a_in(a), .b_in(b), .valid(valid), .ac_bit(ac_bit), .bd_bit(bd_bit));
  ddc_checker i_ddc_checker (.clock(clock), .rstn(rstn), .ce(1'b1),
    .ac_valid(valid), .ac_bit(ac_bit), .bd_valid(valid), .bd_bit(bd_bit),
    .out_valid(out_valid), .out_data(out_data), .out_div_err(out_div_err),
    .err_ack(err_ack), .err_sticky(err_sticky));
  // errors one pair should raise
  function automatic ddc_err_type new_err(ddc_bit_type x, ddc_bit_type y,
    logic s);
    logic ok;
    ok = x.checksum_ok && y.checksum_ok;
    new_err.diversity = ok && (x.antenna_id != y.antenna_id
      || x.unavailable_flag != y.unavailable_flag
      || x.link_test_flag != y.link_test_flag);
    new_err.identity = ok && x.link_id != LNK_ID_AC;
    new_err.counter = s;
  endfunction
  task automatic cmp(input logic [3:0] g, input logic [3:0] x);
    checks_done++;
    if (g !== x)
    begin
      mismatches++;
      $display("wrong value t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic close_out();
    mismatches += int'(cycles > 20000);
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // cycle ceiling against hangs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
      close_out();
  end
  // reset, then random ask bits with corners
  initial
  begin
    void'($urandom(32'h2FBF));
    repeat (12) @(posedge clock);
    #1 rstn = 1'b1;
    for (int i = 0; i < 300; i++)
    begin
      repeat (3) @(posedge clock);
      #1 na = 19'($urandom);
      na.link_id = ($urandom % 8 == 0) ? 2'h3 : LNK_ID_AC;
      na.checksum_ok = ($urandom % 8 != 0);
      nb = na ^ 19'($urandom & $urandom & $urandom);
      nb.link_id = LNK_ID_BD;
      nb.checksum_ok = ($urandom % 8 != 0);
      if (i == 1)
        nb.strength = SS_NONE;
      if (i == 2)
        {nb.checksum_ok, nb.unavailable_flag} = {1'b0, ~na.unavailable_flag};
      // link test pattern: flags and strength identical on both channels
      if (i >= 3 && i <= 6)
      begin
        na.link_test_flag = 1'b1;
        nb[18:10] = na[18:10];
      end
      skip = (i > 0) && ($urandom % 10 == 0);
      e = new_err(na, nb, skip);
      exp_s = exp_s | e;
      m = na & nb;
      a = na;
      b = nb;
      send = 1'b1;
      @(posedge clock);
      #1 send = 1'b0;
      repeat (2) @(posedge clock);
      #1 cmp(4'(out_valid), 4'h1);
      cmp(4'(out_div_err), 4'(e.diversity));
      cmp(4'(out_data.balise_detect), 4'(m.balise_detect));
      cmp(4'(out_data.foreign_telegram_flag), 4'(m[15]));
      if (a.strength == SS_NONE || b.strength == SS_NONE)
        cmp(out_data.strength, SS_NONE);
      else
        cmp(out_data.strength, a.strength);
      cmp(4'(out_data.strength_avail),
        4'(a.strength != SS_NONE && b.strength != SS_NONE));
      cmp(4'(out_data.checks_done),
        4'(a.checksum_ok && b.checksum_ok));
      cmp(out_data.antenna_id, a.antenna_id);
      cmp(4'(out_data.telegram_detect),
        4'(a.telegram_detect | b.telegram_detect));
      cmp(4'(out_data.unavailable_flag),
        4'(a.unavailable_flag | b.unavailable_flag));
      cmp(4'(out_data.link_test_flag),
        4'(a.link_test_flag | b.link_test_flag));
      cmp(4'(err_sticky), 4'(exp_s));
      if ($urandom % 3 == 0)
      begin
        err_ack = 3'h7;
        @(posedge clock);
        #1 err_ack = '0;
        exp_s = '0;
      end
    end
    close_out();
  end
endmodule
